/* hw/wcdc_pkg.sv */
// Constants, types and timing for the winding chopper decay controller.
// Assumes a single 100 MHz clock shared by every user of this package.
// Behaviour
// - Trip reached ends drive, starts selected decay
// - After off time, drive the bridge again
// - Trip reference is sine level times torque scale
// - Torque code 0 is 100%, steps of 6.25%
// - Fast decay reverses the bridge after one dead cycle
// - Fast decay turns bridge off near zero
// - Slow decay turns on both low sides
// - Codes 0-3 pick slow/mixed/fast by direction
// - Codes 4-6 pick mixed or dynamic both ways
// - Decay selection resets to ripple control
// - Decay variant chosen by step direction
// - Full or non-circular half step uses decreasing
// - Slow decay extends while current above trip
// - Mixed: fast leading fraction, then slow
// - Off time 7/16/24/32 us, not ripple
// - Off time change applies after 10 us
// - Comparator blanked 1 us at drive start
package wcdc_pkg;

    localparam int unsigned CLK_PERIOD_NS = 10;

    // Off time choices in microseconds and cycles
    localparam int unsigned OFF_TIME_US_0 = 7;
    localparam int unsigned OFF_TIME_US_1 = 16;
    localparam int unsigned OFF_TIME_US_2 = 24;
    localparam int unsigned OFF_TIME_US_3 = 32;
    localparam logic [11:0] OFF_CYC_0 = 12'((OFF_TIME_US_0 * 1000) / CLK_PERIOD_NS);
    localparam logic [11:0] OFF_CYC_1 = 12'((OFF_TIME_US_1 * 1000) / CLK_PERIOD_NS);
    localparam logic [11:0] OFF_CYC_2 = 12'((OFF_TIME_US_2 * 1000) / CLK_PERIOD_NS);
    localparam logic [11:0] OFF_CYC_3 = 12'((OFF_TIME_US_3 * 1000) / CLK_PERIOD_NS);

    // Blanking and off time deglitch
    localparam int unsigned BLANK_NS = 1000;
    localparam logic [11:0] BLANK_CYC = 12'((BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int unsigned DEGLITCH_US = 10;
    localparam logic [11:0] DEGLITCH_CYC = 12'((DEGLITCH_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Decay selection codes
    localparam logic [2:0] DEC_SLOW_SLOW = 3'h0;
    localparam logic [2:0] DEC_MIX30_SLOW = 3'h1;
    localparam logic [2:0] DEC_SLOW_MIX60 = 3'h2;
    localparam logic [2:0] DEC_SLOW_FAST = 3'h3;
    localparam logic [2:0] DEC_MIX30_BOTH = 3'h4;
    localparam logic [2:0] DEC_MIX60_BOTH = 3'h5;
    localparam logic [2:0] DEC_DYNAMIC = 3'h6;
    localparam logic [2:0] DEC_RIPPLE = 3'h7;

    // Fast share of the off time, percent
    localparam logic [6:0] PCT_SLOW = 7'h00;
    localparam logic [6:0] PCT_MIX30 = 7'h1e;
    localparam logic [6:0] PCT_MIX60 = 7'h3c;
    localparam logic [6:0] PCT_FAST = 7'h64;

    // Reset values
    localparam logic [2:0] DECAY_RST = DEC_RIPPLE;
    localparam logic [1:0] OFF_SEL_RST = 2'h0;
    localparam logic [3:0] TORQUE_RST = 4'h0;

    // Torque scaling: level * (16 - code) / 16
    localparam logic [4:0] TRQ_STEPS = 5'h10;
    localparam int unsigned TRQ_SHIFT = 4;

    typedef enum logic [3:0] {
        ST_DRIVE = 4'b0001,
        ST_FAST = 4'b0010,
        ST_SLOW = 4'b0100,
        ST_RIPPLE = 4'b1000
    } wcdc_state_e;

    typedef struct packed {
        logic [2:0] decay_sel;
        logic [1:0] off_time_select;
        logic [3:0] torque_scale_code;
    } wcdc_cfg_s;

    typedef struct packed {
        logic hs_a;
        logic ls_a;
        logic hs_b;
        logic ls_b;
    } wcdc_gate_s;

    localparam wcdc_gate_s GATE_OFF = 4'h0;
    localparam wcdc_gate_s GATE_POS = 4'h9;
    localparam wcdc_gate_s GATE_NEG = 4'h6;
    localparam wcdc_gate_s GATE_SLOW = 4'h5;

endpackage

/* hw/wcdc_trip_scale.sv */
// Trip reference scaler: sine level times torque scalar, registered.
// Assumes level and code are stable registers on the same clock.
`timescale 1ns/1ps
module wcdc_trip_scale
    import wcdc_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // Operands
    input wire logic [7:0] level_in,
    input wire logic [3:0] code_in,
    // Scaled reference
    output logic [7:0] ref_out
);

    logic [7:0] next_ref;

    always_comb begin
        next_ref = 8'((16'(level_in) * 16'(TRQ_STEPS - {1'b0, code_in})) >> TRQ_SHIFT);
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ref_out <= 8'h00;
        end else begin
            ref_out <= next_ref;
        end
    end

    property p_full_scale;
        @(posedge clk_in) disable iff (srst_in)
        (code_in == 4'h0) |=> (ref_out == $past(level_in));
    endproperty
    a_full_scale: assert property (p_full_scale) else $error("Code 0 not full scale");

    property p_min_scale;
        @(posedge clk_in) disable iff (srst_in)
        (code_in == 4'hf) |=> (ref_out == ($past(level_in) >> 4));
    endproperty
    a_min_scale: assert property (p_min_scale) else $error("Code 15 not one sixteenth");

endmodule

/* hw/wcdc_top.sv */
// Chopper and decay controller for one winding H-bridge.
// Assumes config, step inputs on clk_in; comparators arrive asynchronously.
`timescale 1ns/1ps
module wcdc_top
    import wcdc_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // Settings from the serial port logic
    input wire logic cfg_wr_in,
    input wire wcdc_cfg_s cfg_in,
    // Indexer step target
    input wire logic step_valid_in,
    input wire logic [7:0] sine_level_in,
    input wire logic winding_dir_in,
    input wire logic full_step_mode_in,
    // Analog comparators
    input wire logic trip_cmp_in,
    input wire logic zero_cmp_in,
    input wire logic valley_cmp_in,
    // Bridge and status
    output wcdc_gate_s gate_out,
    output logic [7:0] trip_ref_out,
    output wcdc_state_e phase_out,
    output logic step_rising_out
);

    // Comparator synchronisers
    logic [2:0] cmp_raw;
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic trip_s;
    logic zero_s;
    logic valley_s;

    assign cmp_raw = {valley_cmp_in, zero_cmp_in, trip_cmp_in};

    generate
        for (genvar i = 0; i < 3; i++) begin : g_sync
            always_ff @(posedge clk_in) begin
                if (srst_in) begin
                    sync_a[i] <= 1'b0;
                    sync_b[i] <= 1'b0;
                end else begin
                    sync_a[i] <= cmp_raw[i];
                    sync_b[i] <= sync_a[i];
                end
            end
        end
    endgenerate

    assign trip_s = sync_b[0];
    assign zero_s = sync_b[1];
    assign valley_s = sync_b[2];

    // Settings and off time deglitch
    wcdc_cfg_s cfg;
    wcdc_cfg_s next_cfg;
    logic [1:0] off_sel_act;
    logic [1:0] next_off_sel_act;
    logic [11:0] dg_cnt;
    logic [11:0] next_dg_cnt;

    always_comb begin
        next_cfg = cfg_wr_in ? cfg_in : cfg;
        next_off_sel_act = off_sel_act;
        next_dg_cnt = 12'h000;
        if (cfg.off_time_select != off_sel_act) begin
            if (dg_cnt >= DEGLITCH_CYC - 12'h001) begin
                next_off_sel_act = cfg.off_time_select;
            end else begin
                next_dg_cnt = dg_cnt + 12'h001;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cfg <= {DECAY_RST, OFF_SEL_RST, TORQUE_RST};
            off_sel_act <= OFF_SEL_RST;
            dg_cnt <= 12'h000;
        end else begin
            cfg <= next_cfg;
            off_sel_act <= next_off_sel_act;
            dg_cnt <= next_dg_cnt;
        end
    end

    // Step target and direction classification
    logic [7:0] level;
    logic [7:0] next_level;
    logic dir;
    logic next_dir;
    logic next_rising;

    always_comb begin
        next_level = level;
        next_dir = dir;
        next_rising = step_rising_out;
        if (step_valid_in) begin
            next_level = sine_level_in;
            next_dir = winding_dir_in;
            if (sine_level_in > level) begin
                next_rising = 1'b1;
            end else if (sine_level_in < level) begin
                next_rising = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            level <= 8'h00;
            dir <= 1'b1;
            step_rising_out <= 1'b1;
        end else begin
            level <= next_level;
            dir <= next_dir;
            step_rising_out <= next_rising;
        end
    end

    wcdc_trip_scale u_scale (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .level_in(level),
        .code_in(cfg.torque_scale_code),
        .ref_out(trip_ref_out)
    );

    // Decay scheme for the coming off time
    logic use_dec;
    logic [6:0] fast_pct;
    logic ripple_sel;
    logic [11:0] off_len;
    logic [11:0] fast_cyc;

    always_comb begin
        use_dec = full_step_mode_in | ~step_rising_out;
        fast_pct = PCT_SLOW;
        ripple_sel = 1'b0;
        case (cfg.decay_sel)
            DEC_SLOW_SLOW: fast_pct = PCT_SLOW;
            DEC_MIX30_SLOW: fast_pct = use_dec ? PCT_SLOW : PCT_MIX30;
            DEC_SLOW_MIX60: fast_pct = use_dec ? PCT_MIX60 : PCT_SLOW;
            DEC_SLOW_FAST: fast_pct = use_dec ? PCT_FAST : PCT_SLOW;
            DEC_MIX30_BOTH: fast_pct = PCT_MIX30;
            DEC_MIX60_BOTH: fast_pct = PCT_MIX60;
            DEC_DYNAMIC: fast_pct = use_dec ? PCT_FAST : PCT_MIX30;
            default: ripple_sel = 1'b1;
        endcase
        case (off_sel_act)
            2'h0: off_len = OFF_CYC_0;
            2'h1: off_len = OFF_CYC_1;
            2'h2: off_len = OFF_CYC_2;
            default: off_len = OFF_CYC_3;
        endcase
        fast_cyc = 12'((32'(off_len) * 32'(fast_pct)) / 32'(PCT_FAST));
    end

    // Chopping state machine
    wcdc_state_e state;
    wcdc_state_e next_state;
    logic [11:0] tmr;
    logic [11:0] next_tmr;
    logic [11:0] fast_len;
    logic [11:0] next_fast_len;
    logic zero_hit;
    logic next_zero_hit;

    always_comb begin
        next_state = state;
        next_tmr = tmr;
        next_fast_len = fast_len;
        next_zero_hit = zero_hit;
        case (state)
            ST_DRIVE: begin
                if (tmr < BLANK_CYC) begin
                    next_tmr = tmr + 12'h001;
                end else if (trip_s) begin
                    next_tmr = 12'h000;
                    next_zero_hit = 1'b0;
                    next_fast_len = fast_cyc;
                    if (ripple_sel) begin
                        next_state = ST_RIPPLE;
                    end else if (fast_cyc != 12'h000) begin
                        next_state = ST_FAST;
                    end else begin
                        next_state = ST_SLOW;
                    end
                end
            end
            ST_FAST: begin
                next_tmr = tmr + 12'h001;
                if (zero_s) begin
                    next_zero_hit = 1'b1;
                end
                if (tmr >= fast_len - 12'h001) begin
                    if (fast_len >= off_len) begin
                        next_state = ST_DRIVE;
                        next_tmr = 12'h000;
                    end else begin
                        next_state = ST_SLOW;
                    end
                end
            end
            ST_SLOW: begin
                if (tmr >= off_len - 12'h001) begin
                    next_tmr = 12'h000;
                    if (!trip_s) begin
                        next_state = ST_DRIVE;
                    end
                end else begin
                    next_tmr = tmr + 12'h001;
                end
            end
            ST_RIPPLE: begin
                if (valley_s) begin
                    next_state = ST_DRIVE;
                    next_tmr = 12'h000;
                end
            end
            default: begin
                next_state = ST_DRIVE;
                next_tmr = 12'h000;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state <= ST_DRIVE;
            tmr <= 12'h000;
            fast_len <= 12'h000;
            zero_hit <= 1'b0;
        end else begin
            state <= next_state;
            tmr <= next_tmr;
            fast_len <= next_fast_len;
            zero_hit <= next_zero_hit;
        end
    end

    assign phase_out = state;

    // Bridge gates with break before make
    wcdc_gate_s want_gate;
    wcdc_gate_s next_gate;

    always_comb begin
        case (state)
            ST_DRIVE: want_gate = dir ? GATE_POS : GATE_NEG;
            ST_FAST: want_gate = zero_hit ? GATE_OFF : (dir ? GATE_NEG : GATE_POS);
            ST_SLOW: want_gate = GATE_SLOW;
            ST_RIPPLE: want_gate = GATE_SLOW;
            default: want_gate = GATE_OFF;
        endcase
        next_gate = want_gate;
        if (gate_out != GATE_OFF && want_gate != gate_out) begin
            next_gate = GATE_OFF;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            gate_out <= GATE_OFF;
        end else begin
            gate_out <= next_gate;
        end
    end

    // Checks
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (srst_in);

    property p_trip_leaves_drive;
        (state == ST_DRIVE && tmr >= BLANK_CYC && trip_s) |=> (state != ST_DRIVE);
    endproperty
    a_trip_leaves_drive: assert property (p_trip_leaves_drive) else $error("Trip did not end drive");

    property p_blank_holds;
        (state == ST_DRIVE && tmr < BLANK_CYC) |=> (state == ST_DRIVE && tmr == $past(tmr) + 12'h001);
    endproperty
    a_blank_holds: assert property (p_blank_holds) else $error("Drive ended inside blanking");

    property p_slow_end;
        (state == ST_SLOW && tmr >= off_len - 12'h001 && !trip_s) |=> (state == ST_DRIVE && tmr == 12'h000);
    endproperty
    a_slow_end: assert property (p_slow_end) else $error("No drive after off time");

    property p_slow_extend;
        (state == ST_SLOW && tmr >= off_len - 12'h001 && trip_s) |=> (state == ST_SLOW && tmr == 12'h000);
    endproperty
    a_slow_extend: assert property (p_slow_extend) else $error("Slow decay not extended");

    property p_no_shoot;
        !((gate_out.hs_a && gate_out.ls_a) || (gate_out.hs_b && gate_out.ls_b)) &&
        ($past(gate_out) == GATE_OFF || gate_out == $past(gate_out) || gate_out == GATE_OFF);
    endproperty
    a_no_shoot: assert property (p_no_shoot) else $error("Arm overlap or no dead cycle");

    property p_slow_gates;
        (state == ST_SLOW)[*3] |-> (gate_out == GATE_SLOW);
    endproperty
    a_slow_gates: assert property (p_slow_gates) else $error("Slow decay gates wrong");

    property p_fast_gates;
        (state == ST_FAST && !zero_hit && dir)[*3] |-> (gate_out == GATE_NEG);
    endproperty
    a_fast_gates: assert property (p_fast_gates) else $error("Fast decay not reversed");

    property p_zero_off;
        (state == ST_FAST && zero_hit)[*3] |-> (gate_out == GATE_OFF);
    endproperty
    a_zero_off: assert property (p_zero_off) else $error("Bridge on after zero");

    property p_full_uses_dec;
        (full_step_mode_in && cfg.decay_sel == DEC_SLOW_FAST) |-> (fast_cyc == off_len);
    endproperty
    a_full_uses_dec: assert property (p_full_uses_dec) else $error("Full step ignored decreasing");

    property p_off_deglitch;
        (off_sel_act != $past(off_sel_act)) |-> ($past(dg_cnt) == DEGLITCH_CYC - 12'h001);
    endproperty
    a_off_deglitch: assert property (p_off_deglitch) else $error("Off time applied early");

    c_fast: cover property (state == ST_FAST ##1 state == ST_SLOW);
    c_extend: cover property (state == ST_SLOW && tmr >= off_len - 12'h001 && trip_s);
    c_ripple: cover property (state == ST_RIPPLE ##1 state == ST_DRIVE);
    c_zero: cover property (state == ST_FAST && zero_hit);

endmodule

/* bench/wcdc_winding_model.sv */
// Behavioural winding and bridge: gate pattern in, current comparators out.
// Assumes one magnitude scale shared with trip_ref_out.
`timescale 1ns/1ps
module wcdc_winding_model
    import wcdc_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // Bridge side
    input wire wcdc_gate_s gate_in,
    input wire logic dir_in,
    input wire logic [7:0] ref_in,
    input wire logic hold_trip_in,
    // Comparators
    output logic trip_out,
    output logic zero_out,
    output logic valley_out
);
    int cur;
    int slow_cnt;
    wcdc_gate_s fwd;

    assign fwd = dir_in ? GATE_POS : GATE_NEG;

    // Drive rises fast, recirculation decays slowly, reverse or off decays fast
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cur <= 0;
            slow_cnt <= 0;
        end else if (gate_in == fwd) begin
            cur <= (cur < 400) ? cur + 1 : cur;
        end else if (gate_in == GATE_SLOW) begin
            slow_cnt <= slow_cnt + 1;
            if (slow_cnt % 16 == 15 && cur > 0) begin
                cur <= cur - 1;
            end
        end else begin
            cur <= (cur > 4) ? cur - 4 : 0;
        end
    end

    // Held trip only when a scenario asks for it
    assign trip_out = hold_trip_in || (cur >= int'(ref_in));
    assign zero_out = (cur <= 2);
    assign valley_out = (cur + 8 <= int'(ref_in));
endmodule

/* bench/wcdc_top_test.sv */
// Self-checking bench for the chopper decay controller.
// Assumes wcdc_winding_model closes the loop on the bridge gates.
`timescale 1ns/1ps
module wcdc_top_test
    import wcdc_pkg::*;
;
    typedef struct {
        logic [7:0] lvl;
        logic [3:0] trq;
        logic [7:0] ref_v;
        logic rise;
    } wcdc_row_s;

    logic clk_in, srst_in, cfg_wr_in, step_valid_in, winding_dir_in, full_step_mode_in;
    logic trip_cmp_in, zero_cmp_in, valley_cmp_in, hold_trip, step_rising_out;
    logic [7:0] sine_level_in, trip_ref_out;
    wcdc_cfg_s cfg_in;
    wcdc_gate_s gate_out;
    wcdc_state_e phase_out;
    int err_count, checked, n, n2;
    wcdc_row_s rows [6] = '{'{8'h64, 4'h0, 8'h64, 1'b1}, '{8'hc8, 4'h8, 8'h64, 1'b1},
        '{8'hc8, 4'hf, 8'h0c, 1'b1}, '{8'h28, 4'h4, 8'h1e, 1'b0},
        '{8'hff, 4'h1, 8'hef, 1'b1}, '{8'hff, 4'hf, 8'h0f, 1'b1}};
    logic [3:0] dec_ph [8] = '{4'h4, 4'h4, 4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h8};
    int dec_fast [8] = '{0, 0, 420, 700, 210, 420, 700, 0};

    wcdc_top wcdc_top_i (.clk_in(clk_in), .srst_in(srst_in), .cfg_wr_in(cfg_wr_in), .cfg_in(cfg_in),
        .step_valid_in(step_valid_in), .sine_level_in(sine_level_in), .winding_dir_in(winding_dir_in),
        .full_step_mode_in(full_step_mode_in), .trip_cmp_in(trip_cmp_in), .zero_cmp_in(zero_cmp_in),
        .valley_cmp_in(valley_cmp_in), .gate_out(gate_out), .trip_ref_out(trip_ref_out),
        .phase_out(phase_out), .step_rising_out(step_rising_out));

    wcdc_winding_model wcdc_winding_model_i (.clk_in(clk_in), .srst_in(srst_in), .gate_in(gate_out),
        .dir_in(winding_dir_in), .ref_in(trip_ref_out), .hold_trip_in(hold_trip),
        .trip_out(trip_cmp_in), .zero_out(zero_cmp_in), .valley_out(valley_cmp_in));

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    task automatic final_report();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [11:0] exp, input logic [11:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic tick();
        @(posedge clk_in);
        #1;
    endtask

    task automatic do_reset();
        srst_in = 1'b1;
        repeat (6) tick();
        srst_in = 1'b0;
    endtask

    task automatic wcfg(input logic [2:0] d, input logic [1:0] t, input logic [3:0] q);
        cfg_in = '{decay_sel: d, off_time_select: t, torque_scale_code: q};
        cfg_wr_in = 1'b1;
        tick();
        cfg_wr_in = 1'b0;
    endtask

    task automatic step(input logic [7:0] lvl);
        sine_level_in = lvl;
        step_valid_in = 1'b1;
        tick();
        step_valid_in = 1'b0;
        tick();
    endtask

    // Counts cycles spent in a phase, bounded
    task automatic stay(input wcdc_state_e p, input int bound, output int cnt);
        cnt = 0;
        while (phase_out === p && cnt < bound) begin
            tick();
            cnt++;
        end
        if (cnt >= bound) begin
            err_count++;
            $display("mismatch phase %0h held expected below %0d seen %0d", p, bound, cnt);
            final_report();
        end
    endtask

    // Same arm never fully on
    always @(negedge clk_in) begin
        if ((gate_out.hs_a && gate_out.ls_a) || (gate_out.hs_b && gate_out.ls_b)) begin
            err_count++;
            $display("mismatch arm overlap expected 0 seen %0h", gate_out);
        end
    end

    initial begin
        err_count = 0;
        checked = 0;
        cfg_wr_in = 1'b0;
        cfg_in = '0;
        step_valid_in = 1'b0;
        sine_level_in = 8'h00;
        winding_dir_in = 1'b1;
        full_step_mode_in = 1'b0;
        hold_trip = 1'b0;
        do_reset();
        check("reset gate", 12'h0, 12'(gate_out));
        check("reset phase", 12'(ST_DRIVE), 12'(phase_out));
        check("reset rising", 12'h1, 12'(step_rising_out));
        // Trip reference and step direction table
        foreach (rows[i]) begin
            wcfg(DEC_RIPPLE, 2'h0, rows[i].trq);
            step(rows[i].lvl);
            repeat (3) tick();
            check("trip ref", 12'(rows[i].ref_v), 12'(trip_ref_out));
            check("step rising", 12'(rows[i].rise), 12'(step_rising_out));
        end
        // Every decay code on a decreasing step
        for (int c = 0; c < 8; c++) begin
            do_reset();
            if (c != 7) begin
                wcfg(3'(c), 2'h0, 4'h0);
            end
            step(8'hc8);
            step(8'h64);
            stay(ST_DRIVE, 2000, n);
            check("decay phase", 12'(dec_ph[c]), 12'(phase_out));
            if (dec_fast[c] != 0) begin
                stay(ST_FAST, 2000, n);
                check("fast length", 12'(dec_fast[c]), 12'(n));
            end else if (c == 7) begin
                stay(ST_RIPPLE, 2000, n);
                check("valley end", 12'(ST_DRIVE), 12'(phase_out));
            end
        end
        // Off time change with deglitch, increasing step on slow/slow
        do_reset();
        wcfg(DEC_SLOW_SLOW, 2'h1, 4'h0);
        step(8'hff);
        stay(ST_DRIVE, 2000, n);
        check("slow phase", 12'(ST_SLOW), 12'(phase_out));
        tick();
        check("dead gate", 12'(GATE_OFF), 12'(gate_out));
        tick();
        check("slow gate", 12'(GATE_SLOW), 12'(gate_out));
        stay(ST_SLOW, 4000, n);
        check("old off time", 12'd700, 12'(n + 2));
        stay(ST_DRIVE, 4000, n);
        check("min drive", 12'h1, 12'(n >= 100));
        stay(ST_SLOW, 4000, n);
        check("new off time", 12'd1600, 12'(n));
        // Slow extension while trip held, increasing step on slow/fast
        do_reset();
        wcfg(DEC_SLOW_FAST, 2'h0, 4'h0);
        step(8'hc8);
        stay(ST_DRIVE, 2000, n);
        check("inc slow", 12'(ST_SLOW), 12'(phase_out));
        hold_trip = 1'b1;
        repeat (1000) tick();
        hold_trip = 1'b0;
        stay(ST_SLOW, 2000, n2);
        check("extended slow", 12'd1400, 12'(1000 + n2));
        // Fast decay on a decreasing step, reverse then off near zero
        do_reset();
        wcfg(DEC_SLOW_FAST, 2'h0, 4'h0);
        step(8'hc8);
        step(8'h64);
        check("dec step", 12'h0, 12'(step_rising_out));
        stay(ST_DRIVE, 2000, n);
        tick();
        tick();
        check("reverse gate", 12'(GATE_NEG), 12'(gate_out));
        n = 0;
        while (gate_out !== GATE_OFF && n < 200) begin
            tick();
            n++;
        end
        if (n >= 200) begin
            err_count++;
            $display("mismatch zero wait expected below 200 seen %0d", n);
            final_report();
        end
        check("zero off gate", 12'(GATE_OFF), 12'(gate_out));
        check("still fast", 12'(ST_FAST), 12'(phase_out));
        // Full step mode takes the decreasing variant on a rise
        do_reset();
        full_step_mode_in = 1'b1;
        winding_dir_in = 1'b0;
        wcfg(DEC_SLOW_FAST, 2'h0, 4'h0);
        step(8'hc8);
        tick();
        check("neg drive", 12'(GATE_NEG), 12'(gate_out));
        stay(ST_DRIVE, 2000, n);
        check("full step fast", 12'(ST_FAST), 12'(phase_out));
        tick();
        tick();
        check("neg reverse", 12'(GATE_POS), 12'(gate_out));
        final_report();
    end
endmodule
